//--- design/pbs_defines.vh
// constants for the pipelined burst sram port
// assumes a single clock mclk and a memory controller as the far party
//
// What this block does
// - qualify input high: edge ignored, pipeline state held; write buffer still drains and output enable still acts
// - inputs registered on rising edge, read data launched from output registers
// - read: qualified, all selects active, write strobe high, load low; latch address
// - read data driven after next qualified edge when output enable low
// - any new command accepted on clock right after a read
// - deselect pipelined: outputs float after next qualified edge
// - burst counter serves up to four accesses from one loaded address
// - order select low linear, high interleaved
// - counter uses two low address bits and wraps within four
// - advance high increments counter regardless of selects and strobe
// - read or write type latched at load, kept through burst
// - write: qualified, selects active, strobe low; load address and lane selects
// - edge after write floats drivers regardless of output enable
// - write data captured on second qualified edge after command
// - only selected byte lanes stored, others unchanged
// - burst write advance ignores selects and strobe, increments counter
// - outputs float first clock after leaving deselect
// - power-up deselected, data and parity floating
`ifndef PBS_DEFINES_VH
`define PBS_DEFINES_VH
`define PBS_ADDR_W 18
`define PBS_DATA_W 16
`define PBS_PAR_W 2
`define PBS_WORD_W 18
`define PBS_LANES 2
`define PBS_MEM_DEPTH 262144
`define PBS_FIFO_DEPTH 8
`define PBS_FIFO_AW 3
`define PBS_BURST_ONE 2'h1
`define PBS_BURST_ZERO 2'h0
`define PBS_LANE0_LO 0
`define PBS_LANE0_HI 7
`define PBS_LANE1_LO 8
`define PBS_LANE1_HI 15
`endif

//--- design/pbs_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
module pbs_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge mclk) begin
    if (!rst_b) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

//--- design/pbs_sram_port.v
// synchronous pipelined burst sram device: command pipe, burst counter, core
// assumes pins are resampled by the surrounding pad logic on mclk; rst_b
// stands in for power-up. data pin inputs are synchronised here.
`include "pbs_defines.vh"
module pbs_sram_port (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // command pins
  input wire clock_qualify_n,
  input wire chip_select_a_n,
  input wire chip_select_b,
  input wire chip_select_c_n,
  input wire advance_or_load,
  input wire write_strobe_n,
  input wire [`PBS_LANES-1:0] byte_lane_select_n,
  input wire [`PBS_ADDR_W-1:0] address,
  input wire burst_order,
  input wire output_enable_n,
  // shared data and parity lines, split
  input wire [`PBS_DATA_W-1:0] data_in,
  input wire [`PBS_PAR_W-1:0] shared_parity_lines_in,
  output reg [`PBS_DATA_W-1:0] data_out,
  output reg [`PBS_PAR_W-1:0] shared_parity_lines_out,
  output reg data_oe_n,
  // write fifo back-pressure, stalls the device when full
  output reg write_fifo_full
);
  // ****************************************
  // burst address function
  // ****************************************
  // linear or interleaved
  function [1:0] burst_bits;
    input [1:0] base;
    input [1:0] cnt;
    input order;
    begin
      if (order) begin
        burst_bits = base ^ cnt;
      end else begin
        burst_bits = base + cnt;
      end
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [`PBS_DATA_W-1:0] din_s1_reg;
  reg [`PBS_DATA_W-1:0] din_s2_reg;
  reg [`PBS_PAR_W-1:0] pin_s1_reg;
  reg [`PBS_PAR_W-1:0] pin_s2_reg;
  reg oe_s1_reg;
  reg oe_s2_reg;
  always @(posedge mclk) begin
    din_s1_reg <= data_in;
    din_s2_reg <= din_s1_reg;
    pin_s1_reg <= shared_parity_lines_in;
    pin_s2_reg <= pin_s1_reg;
    oe_s1_reg <= output_enable_n;
    oe_s2_reg <= oe_s1_reg;
  end

  // ****************************************
  // input registers and command decode
  // ****************************************
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`PBS_ADDR_W+`PBS_LANES+`PBS_WORD_W-1:0] fifo_out;
  // the device freezes while the write buffer cannot take a word
  wire qual = !clock_qualify_n && fifo_in_ready;
  wire all_sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  wire cmd_read = qual && all_sel && !advance_or_load && write_strobe_n;
  wire cmd_write = qual && all_sel && !advance_or_load && !write_strobe_n;
  wire cmd_desel = qual && !advance_or_load && !all_sel;
  wire cmd_adv = qual && advance_or_load;

  reg active_reg;
  reg is_write_reg;
  reg [`PBS_ADDR_W-1:0] base_reg;
  reg [1:0] cnt_reg;
  reg [`PBS_ADDR_W-1:0] cur_addr;

  // ****************************************
  // burst counter and pipeline
  // ****************************************
  // stage 1: access launched this cycle, stage 2: write data beat
  reg s1_rd_reg;
  reg s1_wr_reg;
  reg [`PBS_ADDR_W-1:0] s1_addr_reg;
  reg [`PBS_LANES-1:0] s1_bls_reg;
  reg s2_wr_reg;
  reg [`PBS_ADDR_W-1:0] s2_addr_reg;
  reg [`PBS_LANES-1:0] s2_bls_reg;
  reg out_en_reg;

  always @* begin
    cur_addr = base_reg;
    cur_addr[1:0] = burst_bits(base_reg[1:0], cnt_reg + `PBS_BURST_ONE, burst_order);
  end

  wire go_rd = cmd_read || (cmd_adv && active_reg && !is_write_reg);
  wire go_wr = cmd_write || (cmd_adv && active_reg && is_write_reg);
  wire [`PBS_ADDR_W-1:0] go_addr = advance_or_load ? cur_addr : address;

  always @(posedge mclk) begin
    if (!rst_b) begin
      active_reg <= 1'b0;
      is_write_reg <= 1'b0;
      base_reg <= {`PBS_ADDR_W{1'b0}};
      cnt_reg <= `PBS_BURST_ZERO;
      s1_rd_reg <= 1'b0;
      s1_wr_reg <= 1'b0;
      s1_addr_reg <= {`PBS_ADDR_W{1'b0}};
      s1_bls_reg <= {`PBS_LANES{1'b1}};
      s2_wr_reg <= 1'b0;
      s2_addr_reg <= {`PBS_ADDR_W{1'b0}};
      s2_bls_reg <= {`PBS_LANES{1'b1}};
    end else if (qual) begin
      if (cmd_read || cmd_write) begin
        active_reg <= 1'b1;
        is_write_reg <= cmd_write;
        base_reg <= address;
        cnt_reg <= `PBS_BURST_ZERO;
      end else if (cmd_desel) begin
        active_reg <= 1'b0;
      end else if (cmd_adv && active_reg) begin
        cnt_reg <= cnt_reg + `PBS_BURST_ONE;
      end
      s1_rd_reg <= go_rd;
      s1_wr_reg <= go_wr;
      s1_addr_reg <= go_addr;
      s1_bls_reg <= byte_lane_select_n;
      s2_wr_reg <= s1_wr_reg;
      s2_addr_reg <= s1_addr_reg;
      // lanes of each beat follow their data down the pipe
      s2_bls_reg <= s1_bls_reg;
    end
  end

  // ****************************************
  // write buffer and core
  // ****************************************
  // captured write word plus lane mask wait in the fifo until the core takes them
  wire fifo_push = qual && s2_wr_reg;
  wire [`PBS_ADDR_W+`PBS_LANES+`PBS_WORD_W-1:0] fifo_in =
    {s2_addr_reg, s2_bls_reg, pin_s2_reg, din_s2_reg};

  // the core is busy on read cycles; writes drain when no read launches
  wire core_ready = !(qual && go_rd);

  pbs_fifo #(
    .WIDTH(`PBS_ADDR_W + `PBS_LANES + `PBS_WORD_W),
    .DEPTH(`PBS_FIFO_DEPTH),
    .AW(`PBS_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(core_ready),
    .out_data(fifo_out)
  );

  reg [`PBS_WORD_W-1:0] core_reg [0:`PBS_MEM_DEPTH-1];
  wire [`PBS_ADDR_W-1:0] drain_addr = fifo_out[`PBS_ADDR_W+`PBS_LANES+`PBS_WORD_W-1:
                                               `PBS_LANES+`PBS_WORD_W];
  wire [`PBS_LANES-1:0] drain_bls = fifo_out[`PBS_LANES+`PBS_WORD_W-1:`PBS_WORD_W];
  wire [`PBS_WORD_W-1:0] drain_word = fifo_out[`PBS_WORD_W-1:0];
  wire drain = fifo_out_valid && core_ready;

  always @(posedge mclk) begin
    if (drain) begin
      if (!drain_bls[0]) begin
        core_reg[drain_addr][`PBS_LANE0_HI:`PBS_LANE0_LO] <=
          drain_word[`PBS_LANE0_HI:`PBS_LANE0_LO];
        core_reg[drain_addr][`PBS_DATA_W] <= drain_word[`PBS_DATA_W];
      end
      if (!drain_bls[1]) begin
        core_reg[drain_addr][`PBS_LANE1_HI:`PBS_LANE1_LO] <=
          drain_word[`PBS_LANE1_HI:`PBS_LANE1_LO];
        core_reg[drain_addr][`PBS_DATA_W+1] <= drain_word[`PBS_DATA_W+1];
      end
    end
  end

  // ****************************************
  // read data with forwarding from the write draining this cycle
  // ****************************************
  // a read sees a buffered write to its word only if it has drained or drains on the data_out edge
  reg [`PBS_WORD_W-1:0] rd_word;
  always @* begin
    rd_word = core_reg[s1_addr_reg];
    if (drain && drain_addr == s1_addr_reg) begin
      if (!drain_bls[0]) begin
        rd_word[`PBS_LANE0_HI:`PBS_LANE0_LO] = drain_word[`PBS_LANE0_HI:`PBS_LANE0_LO];
        rd_word[`PBS_DATA_W] = drain_word[`PBS_DATA_W];
      end
      if (!drain_bls[1]) begin
        rd_word[`PBS_LANE1_HI:`PBS_LANE1_LO] = drain_word[`PBS_LANE1_HI:`PBS_LANE1_LO];
        rd_word[`PBS_DATA_W+1] = drain_word[`PBS_DATA_W+1];
      end
    end
  end

  // ****************************************
  // output registers and drive control
  // ****************************************
  always @(posedge mclk) begin
    if (!rst_b) begin
      data_out <= {`PBS_DATA_W{1'b0}};
      shared_parity_lines_out <= {`PBS_PAR_W{1'b0}};
      out_en_reg <= 1'b0;
      data_oe_n <= 1'b1;
      write_fifo_full <= 1'b0;
    end else begin
      write_fifo_full <= !fifo_in_ready;
      if (qual) begin
        // read from the input stage, launched one edge later
        if (s1_rd_reg) begin
          data_out <= rd_word[`PBS_DATA_W-1:0];
          shared_parity_lines_out <= rd_word[`PBS_WORD_W-1:`PBS_DATA_W];
        end
        // float on deselect, write, first read
        out_en_reg <= go_rd && !((cmd_read) && !active_reg);
      end
      data_oe_n <= !(out_en_reg && !oe_s2_reg);
    end
  end
endmodule

//--- bench/pbs_sram_port_asserts.sv
// checker for the burst sram port, bound into every pbs_sram_port
// assumes one clock mclk and the port names of the design top
`include "pbs_defines.vh"
module pbs_sram_port_chk (
  input logic mclk,
  input logic rst_b,
  input logic clock_qualify_n,
  input logic chip_select_a_n,
  input logic chip_select_b,
  input logic chip_select_c_n,
  input logic advance_or_load,
  input logic write_strobe_n,
  input logic output_enable_n,
  input logic [`PBS_DATA_W-1:0] data_out,
  input logic data_oe_n,
  input logic write_fifo_full
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // command decode
  // ****
  wire q = !clock_qualify_n && !write_fifo_full;
  wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  wire ld = q && !advance_or_load;
  wire rd = ld && sel && write_strobe_n;
  wire wr = ld && sel && !write_strobe_n;
  wire ds = ld && !sel;
  wire rdx = q && !output_enable_n && (rd || advance_or_load);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_suspend_holds: assert property (clock_qualify_n |=> $stable(data_out))
    else $error("data_out moved on an unqualified edge");
  a_reset_idle: assert property (disable iff (1'b0) !rst_b |=> data_oe_n && !write_fifo_full)
    else $error("lines driven or buffer full after reset");
  a_deselect_float: assert property (ds ##1 q |=> data_oe_n)
    else $error("lines driven after deselect");
  a_write_float: assert property (wr ##1 q |=> data_oe_n)
    else $error("lines driven in write data cycle");
  a_first_read_float: assert property (ds ##1 rd ##1 1'b1 |=> data_oe_n)
    else $error("first read after deselect drove lines");
  a_oe_high_float: assert property (output_enable_n [*3] |=> data_oe_n)
    else $error("lines driven with output enable high");
  a_read_drives: assert property (rd && !output_enable_n ##1 rdx ##1 rdx ##1 q && !output_enable_n
      |=> !data_oe_n)
    else $error("back to back read not driven");
  a_data_moves: assert property ($changed(data_out) |-> $past(rd || (q && advance_or_load), 2))
    else $error("data_out changed without a read");
  c_burst_read: cover property (rd ##1 rdx ##1 rdx ##1 rdx);
  c_write_read: cover property (wr ##1 rd);
  c_suspend: cover property (clock_qualify_n [*3]);
endmodule
bind pbs_sram_port pbs_sram_port_chk chk_u (.*);

//--- bench/pbs_ctrl_model.sv
// memory controller model driving the sram port pins
// assumes the bench calls cmd once per cycle, one caller at a time
`include "pbs_defines.vh"
module pbs_ctrl_model (
  // clock
  input logic mclk,
  // command pins
  output logic clock_qualify_n,
  output logic chip_select_a_n,
  output logic chip_select_b,
  output logic chip_select_c_n,
  output logic advance_or_load,
  output logic write_strobe_n,
  output logic [`PBS_LANES-1:0] byte_lane_select_n,
  output logic [`PBS_ADDR_W-1:0] address,
  output logic burst_order,
  output logic output_enable_n,
  // shared lines, resolved here
  output logic [`PBS_DATA_W-1:0] data_in,
  output logic [`PBS_PAR_W-1:0] shared_parity_lines_in,
  input logic [`PBS_DATA_W-1:0] data_out,
  input logic [`PBS_PAR_W-1:0] shared_parity_lines_out,
  input logic data_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [17:0] word = 18'h0;
  logic [17:0] last = 18'h0;
  logic wburst = 1'b0;
  int hold = 0;
  // ****
  // line resolution
  // ****
  // enable low except while write data is out
  assign output_enable_n = (hold != 0);
  // undriven lines toggle so stale data never reads as good
  assign {shared_parity_lines_in, data_in} = !data_oe_n ?
      {shared_parity_lines_out, data_out} : (hold != 0) ? word : ~last;
  always @(posedge mclk) begin
    last <= {shared_parity_lines_in, data_in};
    if (hold != 0) hold <= hold - 1;
  end
  initial begin
    {clock_qualify_n, chip_select_a_n, chip_select_b, chip_select_c_n} = 4'hd;
    {advance_or_load, write_strobe_n, byte_lane_select_n, address, burst_order} = 23'h300000;
  end
  // k: 0 deselect, 1 read, 2 write, 3 advance, 4 unqualified read
  // command encoding
  task automatic cmd(input logic [2:0] k, input logic [17:0] a, input logic [1:0] ln,
      input logic [17:0] w, input logic o);
    @(posedge mclk);
    #1;
    clock_qualify_n = (k == 3'h4);
    {chip_select_a_n, chip_select_b, chip_select_c_n} = (k == 3'h0 || k == 3'h3) ? 3'h5 : 3'h2;
    advance_or_load = (k == 3'h3);
    write_strobe_n = !(k == 3'h2 || k == 3'h3);
    byte_lane_select_n = ln;
    address = a;
    burst_order = o;
    if (k == 3'h1) wburst = 1'b0;
    if (k == 3'h2) wburst = 1'b1;
    // data held to the second edge, lanes every beat
    if (k == 3'h2 || (k == 3'h3 && wburst)) begin
      word = w;
      hold = 3;
    end
  endtask
endmodule

//--- bench/pipelined_burst_sram_port_tb.sv
// self-checking bench for pbs_sram_port driven through the controller model
// assumes the checker bind and the model are compiled before this file
`include "pbs_defines.vh"
module pipelined_burst_sram_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic w; logic [1:0] ln; logic [17:0] a; logic [17:0] d;} pbs_row_t;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  wire clock_qualify_n, chip_select_a_n, chip_select_b, chip_select_c_n, advance_or_load;
  wire write_strobe_n, burst_order, output_enable_n, data_oe_n, write_fifo_full;
  wire [`PBS_LANES-1:0] byte_lane_select_n;
  wire [`PBS_ADDR_W-1:0] address;
  wire [`PBS_DATA_W-1:0] data_in, data_out;
  wire [`PBS_PAR_W-1:0] shared_parity_lines_in, shared_parity_lines_out;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [17:0] mem [logic [17:0]];
  // reads carry the word they should return in d
  pbs_row_t rows [10] = '{
    '{1'b1, 2'h0, 18'h00100, 18'h21234}, '{1'b0, 2'h3, 18'h00100, 18'h21234},
    '{1'b1, 2'h2, 18'h00100, 18'h1abcd}, '{1'b0, 2'h3, 18'h00100, 18'h312cd},
    '{1'b1, 2'h1, 18'h00100, 18'h0ef00}, '{1'b0, 2'h3, 18'h00100, 18'h1efcd},
    '{1'b1, 2'h3, 18'h00100, 18'h3ffff}, '{1'b0, 2'h3, 18'h00100, 18'h1efcd},
    '{1'b1, 2'h0, 18'h3ffff, 18'h25a5a}, '{1'b0, 2'h3, 18'h3ffff, 18'h25a5a}};
  pbs_sram_port dut_u (.*);
  pbs_ctrl_model ctl_u (.*);
  always #2.5 mclk = ~mclk;
  // ****
  // helpers
  // ****
  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [17:0] a, input logic [1:0] ln, input logic [17:0] d);
    logic [17:0] m;
    m = mem.exists(a) ? mem[a] : 18'h0;
    // lane zero is bits 7:0 with parity 0
    if (!ln[0]) m = {m[17], d[16], m[15:8], d[7:0]};
    if (!ln[1]) m = {d[17], m[16], d[15:8], m[7:0]};
    mem[a] = m;
  endtask
  task automatic gap(input int n);
    repeat (n) ctl_u.cmd(3'h0, 18'h0, 2'h3, 18'h0, 1'b0);
  endtask
  // two idle edges so data_out has landed
  task automatic rd(input logic [17:0] a, input logic [17:0] e);
    ctl_u.cmd(3'h1, a, 2'h3, 18'h0, 1'b0);
    gap(2);
    cmp({2'h0, shared_parity_lines_out, data_out}, {2'h0, e});
  endtask
  function automatic logic [17:0] beat(input logic [17:0] a, input logic o, input int j);
    // add or xor in the low two bits, wrap in four
    beat = {a[17:2], o ? a[1:0] ^ j[1:0] : a[1:0] + j[1:0]};
  endfunction
  // advances carry idle selects and a write strobe that must be ignored
  task automatic burst(input logic w, input logic [17:0] a, input logic o, input logic v);
    logic [17:0] d;
    for (int k = 0; k < 6; k++) begin
      d = (v ? 18'h2c3c0 : 18'h15a00) + 18'(k);
      if (k < 4) ctl_u.cmd(k == 0 ? {1'b0, w, !w} : 3'h3, a, v ? k[1:0] : 2'h0, d, o);
      else gap(1);
      if (w && k < 4) put(beat(a, o, k), v ? k[1:0] : 2'h0, d);
      if (!w && k > 1) cmp({2'h0, shared_parity_lines_out, data_out},
          {2'h0, mem[beat(a, o, k - 2)]});
      if (!w && k > 1) cmp({19'h0, data_oe_n}, {19'h0, k == 2});
    end
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      give_verdict;
    end
  end
  // ****
  // sequence
  // ****
  initial begin
    repeat (8) @(posedge mclk);
    #1 rst_b = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        ctl_u.cmd(3'h2, rows[i].a, rows[i].ln, rows[i].d, 1'b0);
        put(rows[i].a, rows[i].ln, rows[i].d);
        gap(4);
      end else rd(rows[i].a, rows[i].d);
    end
    burst(1'b1, 18'h00202, 1'b1, 1'b0);
    gap(4);
    burst(1'b1, 18'h00203, 1'b0, 1'b1);
    gap(4);
    burst(1'b0, 18'h00201, 1'b0, 1'b0);
    burst(1'b0, 18'h00203, 1'b1, 1'b0);
    rd(18'h00100, 18'h1efcd);
    repeat (3) ctl_u.cmd(3'h4, 18'h3ffff, 2'h3, 18'h0, 1'b0);
    gap(2);
    cmp({2'h0, shared_parity_lines_out, data_out}, 20'h1efcd);
    // write then read on the very next edge
    ctl_u.cmd(3'h2, 18'h00300, 2'h0, 18'h0c0de, 1'b0);
    rd(18'h3ffff, 18'h25a5a);
    gap(3);
    rd(18'h00300, 18'h0c0de);
    @(posedge mclk);
    #1 rst_b = 1'b0;
    repeat (3) @(posedge mclk);
    #1 cmp({data_oe_n, write_fifo_full, shared_parity_lines_out, data_out}, 20'h80000);
    give_verdict;
  end
endmodule
